// *** inc/break_trace_pkg.sv ***
package break_trace_pkg;

    // ****************************************
    // target modes
    // ****************************************
    typedef enum logic [1:0] {
        MODE_SMALL,
        MODE_MEDIUM,
        MODE_LARGE
    } target_mode_t;

    localparam logic [12:0] LAST_ADDR_SMALL  = 13'h07df;
    localparam logic [12:0] LAST_ADDR_MEDIUM = 13'h0fdf;
    localparam logic [12:0] LAST_ADDR_LARGE  = 13'h1fdf;
    localparam int          CODE_DEPTH       = 8192;

    // ****************************************
    // trace signal selections
    // ****************************************
    localparam logic [1:0] SEL_BANK     = 2'h1;
    localparam logic [1:0] SEL_P4_P0    = 2'h2;
    localparam logic [1:0] SEL_P4_P1    = 2'h3;
    localparam logic [1:0] SEL_RESET    = SEL_BANK;

    // ****************************************
    // break causes
    // ****************************************
    typedef enum logic [3:0] {
        CAUSE_NONE,
        CAUSE_ESCAPE,
        CAUSE_BREAKPOINT,
        CAUSE_TRACE_OVERFLOW,
        CAUSE_CYCLE_OVERFLOW,
        CAUSE_ADDR_MATCH,
        CAUSE_ADDR_PASS,
        CAUSE_DATA_PASS,
        CAUSE_ACC_PASS,
        CAUSE_OUT_OF_AREA
    } break_cause_t;

    localparam logic [12:0] TRACE_PTR_RESET = 13'h0000;
    localparam logic [31:0] CYCLE_RESET     = 32'h0000_0000;

endpackage

// *** rtl/emulator_break_trace_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module emulator_break_trace_control #(
    parameter int ADDR_W  = 13,
    parameter int TRACE_W = 13,
    parameter int CYCLE_W = 32
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic [1:0]           target_mode,
    input  wire logic                 sel_write,
    input  wire logic [1:0]           sel_value,
    output logic      [1:0]           trace_select,
    input  wire logic                 bp_write,
    input  wire logic [ADDR_W-1:0]    bp_addr,
    input  wire logic                 bp_value,
    output logic                      bp_read,
    input  wire logic                 en_breakpoint,
    input  wire logic                 en_trace_overflow,
    input  wire logic                 en_cycle_overflow,
    input  wire logic                 run_start,
    input  wire logic                 fetch_valid,
    input  wire logic                 fetch_first,
    input  wire logic [ADDR_W-1:0]    fetch_addr,
    input  wire logic                 core_cycle,
    input  wire logic                 escape_key,
    input  wire logic                 addr_match,
    input  wire logic                 addr_pass,
    input  wire logic                 data_pass,
    input  wire logic                 acc_pass,
    input  wire logic                 bank_common_flag,
    input  wire logic                 bank_enable_flag,
    input  wire logic [2:0]           bank_select_zero,
    input  wire logic [2:0]           bank_select_one,
    input  wire logic [3:0]           port_four,
    input  wire logic [3:0]           port_zero,
    input  wire logic [3:0]           port_one,
    output logic      [7:0]           trace_field,
    output logic      [TRACE_W-1:0]   trace_pointer,
    output logic                      running,
    output logic                      break_pulse,
    output logic      [3:0]           break_cause,
    output logic      [CYCLE_W-1:0]   cycle_count
);

    // ****************************************
    // mode decoding
    // ****************************************
    function automatic logic [ADDR_W-1:0] last_addr(input logic [1:0] m);
        unique case (m)
            break_trace_pkg::MODE_SMALL:  last_addr = ADDR_W'(break_trace_pkg::LAST_ADDR_SMALL);
            break_trace_pkg::MODE_MEDIUM: last_addr = ADDR_W'(break_trace_pkg::LAST_ADDR_MEDIUM);
            default:                      last_addr = ADDR_W'(break_trace_pkg::LAST_ADDR_LARGE);
        endcase
    endfunction

    // ****************************************
    // breakpoint memory
    // ****************************************
    // no reset on the array: software loads it before each run
    logic bp_mem [0:(1<<ADDR_W)-1];
    logic bp_hit;
    logic bp_wr_ok;

    assign bp_wr_ok = bp_write && (bp_addr <= last_addr(target_mode));

    always_ff @(posedge mclk)
    begin
        if (bp_wr_ok)
        begin
            bp_mem[bp_addr] <= bp_value;
        end
        bp_read <= bp_mem[bp_addr];
        bp_hit  <= bp_mem[fetch_addr];
    end

    // ****************************************
    // trace selection and pointer
    // ****************************************
    logic [1:0]         next_trace_select;
    logic [TRACE_W-1:0] next_trace_pointer;
    logic [7:0]         next_trace_field;
    logic               trace_wrap;
    logic               small_mode;

    assign small_mode = (target_mode == break_trace_pkg::MODE_SMALL);
    assign trace_wrap = running && core_cycle && (&trace_pointer);

    always_comb
    begin
        next_trace_select  = trace_select;
        next_trace_pointer = trace_pointer;
        if (sel_write && (sel_value != 2'h0))
        begin
            next_trace_select = sel_value;
        end
        if (run_start)
        begin
            next_trace_pointer = TRACE_W'(break_trace_pkg::TRACE_PTR_RESET);
        end
        else if (running && core_cycle)
        begin
            next_trace_pointer = trace_pointer + 1'b1;
        end
        if (next_trace_select != trace_select)
        begin
            next_trace_pointer = TRACE_W'(break_trace_pkg::TRACE_PTR_RESET);
        end
        unique case (trace_select)
            break_trace_pkg::SEL_P4_P0:
                next_trace_field = {small_mode ? 4'h0 : port_four, port_zero};
            break_trace_pkg::SEL_P4_P1:
                next_trace_field = {small_mode ? 4'h0 : port_four, port_one};
            default:
                next_trace_field = {bank_common_flag, bank_select_zero,
                                    bank_enable_flag, bank_select_one};
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            trace_select  <= break_trace_pkg::SEL_RESET;
            trace_pointer <= TRACE_W'(break_trace_pkg::TRACE_PTR_RESET);
            trace_field   <= 8'h00;
        end
        else
        begin
            trace_select  <= next_trace_select;
            trace_pointer <= next_trace_pointer;
            trace_field   <= next_trace_field;
        end
    end

    // ****************************************
    // break detection
    // ****************************************
    // breakpoint bit is read one cycle after the fetch, so fetch info is delayed to match
    logic               fetch_d;
    logic               fetch_first_d;
    logic [ADDR_W-1:0]  fetch_addr_d;
    logic               cycle_wrap;
    logic               next_running;
    logic [3:0]         next_cause;
    logic [CYCLE_W-1:0] next_cycle;
    logic               next_break;

    assign cycle_wrap = running && core_cycle && (&cycle_count);

    always_comb
    begin
        next_cause   = break_cause;
        next_running = running;
        next_cycle   = cycle_count;
        next_break   = 1'b0;
        if (running && core_cycle)
        begin
            next_cycle = cycle_count + 1'b1;
        end
        if (running)
        begin
            next_break = 1'b1;
            // fixed priority: first matching cause is the one recorded
            if (escape_key)
                next_cause = break_trace_pkg::CAUSE_ESCAPE;
            else if (fetch_d && (fetch_addr_d > last_addr(target_mode)))
                next_cause = break_trace_pkg::CAUSE_OUT_OF_AREA;
            else if (en_breakpoint && fetch_d && fetch_first_d && bp_hit)
                next_cause = break_trace_pkg::CAUSE_BREAKPOINT;
            else if (en_trace_overflow && trace_wrap)
                next_cause = break_trace_pkg::CAUSE_TRACE_OVERFLOW;
            else if (en_cycle_overflow && cycle_wrap)
                next_cause = break_trace_pkg::CAUSE_CYCLE_OVERFLOW;
            else if (addr_match)
                next_cause = break_trace_pkg::CAUSE_ADDR_MATCH;
            else if (addr_pass)
                next_cause = break_trace_pkg::CAUSE_ADDR_PASS;
            else if (data_pass)
                next_cause = break_trace_pkg::CAUSE_DATA_PASS;
            else if (acc_pass)
                next_cause = break_trace_pkg::CAUSE_ACC_PASS;
            else
                next_break = 1'b0;
            if (next_break)
            begin
                next_running = 1'b0;
            end
        end
        if (run_start)
        begin
            next_running = 1'b1;
            next_break   = 1'b0;
            next_cause   = break_trace_pkg::CAUSE_NONE;
            next_cycle   = CYCLE_W'(break_trace_pkg::CYCLE_RESET);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            running       <= 1'b0;
            break_pulse   <= 1'b0;
            break_cause   <= break_trace_pkg::CAUSE_NONE;
            cycle_count   <= CYCLE_W'(break_trace_pkg::CYCLE_RESET);
            fetch_d       <= 1'b0;
            fetch_first_d <= 1'b0;
            fetch_addr_d  <= '0;
        end
        else
        begin
            running       <= next_running;
            break_pulse   <= next_break;
            break_cause   <= next_cause;
            cycle_count   <= next_cycle;
            fetch_d       <= fetch_valid && running;
            fetch_first_d <= fetch_first;
            fetch_addr_d  <= fetch_addr;
        end
    end

endmodule

`default_nettype wire

// *** sim/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// emulated core model
// ****************************************
module core_model (
    input  wire logic        mclk,
    output logic             fetch_valid,
    output logic             fetch_first,
    output logic [12:0]      fetch_addr,
    output logic             core_cycle
);
    // a core cycle every clock keeps the pointer overflow run short
    initial {fetch_valid, fetch_first, fetch_addr, core_cycle} = 16'h0001;
    task automatic fetch(input logic [12:0] a, input logic f);
        @(negedge mclk) {fetch_valid, fetch_first, fetch_addr} = {1'b1, f, a};
        // a released address bus does not keep its last value
        @(negedge mclk) {fetch_valid, fetch_first, fetch_addr} = {2'b00, ~a};
        repeat (3) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// *** sim/emulator_break_trace_control_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module emulator_break_trace_control_checker #(
    parameter int ADDR_W  = 13,
    parameter int TRACE_W = 13,
    parameter int CYCLE_W = 32
) (
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire logic [1:0]         target_mode,
    input wire logic               sel_write,
    input wire logic [1:0]         sel_value,
    input wire logic [1:0]         trace_select,
    input wire logic               run_start,
    input wire logic               fetch_valid,
    input wire logic               fetch_first,
    input wire logic [ADDR_W-1:0]  fetch_addr,
    input wire logic               escape_key,
    input wire logic [7:0]         trace_field,
    input wire logic [TRACE_W-1:0] trace_pointer,
    input wire logic               running,
    input wire logic               break_pulse,
    input wire logic [3:0]         break_cause,
    input wire logic [CYCLE_W-1:0] cycle_count
);
    logic [12:0] last;
    assign last = target_mode == 2'h0 ? break_trace_pkg::LAST_ADDR_SMALL :
        target_mode == 2'h1 ? break_trace_pkg::LAST_ADDR_MEDIUM : break_trace_pkg::LAST_ADDR_LARGE;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_SEL_CLEAR: assert property (sel_write && sel_value != 2'h0 && sel_value != trace_select
        |=> trace_pointer == '0) else $error("pointer kept on selection change");
    AST_SEL_ZERO: assert property (sel_write && sel_value == 2'h0
        |=> $stable(trace_select)) else $error("selection code zero taken");
    AST_RESET: assert property (disable iff (1'b0) !rst_n
        |=> trace_select == 2'h1 && break_cause == 4'h0) else $error("bad reset state");
    AST_BP_FIRST: assert property (break_pulse && break_cause == 4'h2
        |-> $past(fetch_valid, 2) && $past(fetch_first, 2)) else $error("breakpoint without fetch");
    AST_PULSE: assert property (break_pulse
        |-> !running ##1 !break_pulse) else $error("break pulse shape");
    AST_HOLD: assert property (!running && !run_start
        |=> $stable(break_cause) && $stable(cycle_count)) else $error("record changed while stopped");
    AST_RUN: assert property (run_start
        |=> running && break_cause == 4'h0 && cycle_count == '0) else $error("run start state");
    AST_AREA: assert property (running && fetch_valid && !escape_key && fetch_addr > last
        |-> ##2 break_pulse && break_cause == 4'h9) else $error("no out of area break");
    AST_SMALL_P4: assert property (target_mode == 2'h0 && !sel_write && trace_select != 2'h1
        |=> trace_field[7:4] == 4'h0) else $error("port four traced in small mode");
endmodule
bind emulator_break_trace_control emulator_break_trace_control_checker #(.ADDR_W(ADDR_W),
    .TRACE_W(TRACE_W), .CYCLE_W(CYCLE_W)) chk (.mclk(mclk), .rst_n(rst_n),
    .target_mode(target_mode), .sel_write(sel_write), .sel_value(sel_value),
    .trace_select(trace_select), .run_start(run_start), .fetch_valid(fetch_valid),
    .fetch_first(fetch_first), .fetch_addr(fetch_addr), .escape_key(escape_key),
    .trace_field(trace_field), .trace_pointer(trace_pointer), .running(running),
    .break_pulse(break_pulse), .break_cause(break_cause), .cycle_count(cycle_count));
`default_nettype wire

// *** sim/emulator_break_trace_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module emulator_break_trace_control_test;
    logic        mclk = 1'b0, rst_n = 1'b0, sel_write = 1'b0, bp_write = 1'b0;
    logic        bp_value = 1'b0, run_start = 1'b0;
    logic [1:0]  mode = 2'h1, sel_value = 2'h0, cur = 2'h1, ts;
    logic [12:0] bp_addr = 13'h0000, fa, tp;
    logic [2:0]  en = 3'h0;
    logic [4:0]  req = 5'h00;
    logic [19:0] src = 20'h0_0000;
    logic [31:0] seed = 32'h0000_4618, cnt;
    logic        fv, ff, cc, rd, brk, run;
    logic [7:0]  tf;
    logic [3:0]  cause, pend[$];
    int          n_fail = 0, checks_done = 0;
    emulator_break_trace_control uut (.mclk(mclk), .rst_n(rst_n), .target_mode(mode),
        .sel_write(sel_write), .sel_value(sel_value), .trace_select(ts), .bp_write(bp_write),
        .bp_addr(bp_addr), .bp_value(bp_value), .bp_read(rd), .en_breakpoint(en[2]),
        .en_trace_overflow(en[1]), .en_cycle_overflow(en[0]), .run_start(run_start),
        .fetch_valid(fv), .fetch_first(ff), .fetch_addr(fa), .core_cycle(cc),
        .escape_key(req[4]), .addr_match(req[3]), .addr_pass(req[2]), .data_pass(req[1]),
        .acc_pass(req[0]), .bank_common_flag(src[19]), .bank_select_zero(src[18:16]),
        .bank_enable_flag(src[15]), .bank_select_one(src[14:12]), .port_four(src[11:8]),
        .port_zero(src[7:4]), .port_one(src[3:0]), .trace_field(tf), .trace_pointer(tp),
        .running(run), .break_pulse(brk), .break_cause(cause), .cycle_count(cnt));
    core_model core (.mclk(mclk), .fetch_valid(fv), .fetch_first(ff), .fetch_addr(fa),
        .core_cycle(cc));
    always #2.5 mclk = ~mclk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // the monitor pairs each break with the oldest expected cause
    always @(negedge mclk)
        if (brk === 1'b1)
            chk("break cause", pend.size() ? pend.pop_front() : 4'hf, cause);
    // the expected cause is queued by the caller before the break reaches the monitor
    task automatic brk_wait();
        int          i;
        logic [31:0] held;
        for (i = 0; i < 9000 && run !== 1'b0; i++)
            @(negedge mclk);
        if (i == 9000)
        begin
            chk("timeout", 0, 1);
            finish_test();
        end
        held = cnt;
        @(negedge mclk) chk("pending", 0, pend.size());
        chk("count held", held, cnt);
    endtask
    task automatic go();
        @(negedge mclk) run_start = 1'b1;
        @(negedge mclk) run_start = 1'b0;
        chk("running", 1, run);
        chk("count", 0, cnt);
    endtask
    task automatic bp(input logic [12:0] a, input logic v);
        @(negedge mclk) {bp_write, bp_addr, bp_value} = {1'b1, a, v};
        @(negedge mclk) bp_write = 1'b0;
    endtask
    initial
    begin
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        chk("select", 2'h1, ts);
        chk("cause", 0, cause);
        go();
        for (int s = 0; s < 8; s++)
        begin
            @(negedge mclk) {sel_write, sel_value, mode, src} = {1'b1, 2'(s), s[2] ? 2'h0 : 2'h2,
                20'(xs())};
            @(negedge mclk) sel_write = 1'b0;
            if (s[1:0] != 2'h0 && s[1:0] != cur)
                chk("pointer", 0, tp);
            cur = s[1:0] != 2'h0 ? 2'(s) : cur;
            @(negedge mclk) chk("select", cur, ts);
            chk("field", cur == 2'h1 ? src[19:12] : {s[2] ? 4'h0 : src[11:8],
                cur == 2'h2 ? src[7:4] : src[3:0]}, tf);
        end
        for (int i = 0; i < 5; i++)
        begin
            @(negedge mclk) req = 5'h10 >> i;
            pend.push_back(i == 0 ? 4'h1 : 4'(4 + i));
            brk_wait();
            req = 5'h00;
            go();
        end
        mode = 2'h2;
        bp(13'h07e0, 1'b0);
        bp(13'h07df, 1'b1);
        bp(13'h07de, 1'b1);
        mode = 2'h0;
        bp(13'h07e0, 1'b1);
        @(negedge mclk) chk("bp bit", 0, rd);
        core.fetch(13'h07df, 1'b1);
        en = 3'h4;
        core.fetch(13'h07de, 1'b0);
        chk("running", 1, run);
        pend.push_back(4'h2);
        core.fetch(13'h07df, 1'b1);
        brk_wait();
        en = 3'h0;
        for (int m = 0; m < 3; m++)
        begin
            mode = 2'(m);
            go();
            core.fetch(m == 0 ? 13'h07df : m == 1 ? 13'h0fdf : 13'h1fdf, 1'b0);
            chk("running", 1, run);
            pend.push_back(4'h9);
            core.fetch(m == 0 ? 13'h07e0 : m == 1 ? 13'h0fe0 : 13'h1fe0, 1'b0);
            brk_wait();
        end
        go();
        en = 3'h2;
        pend.push_back(4'h3);
        brk_wait();
        finish_test();
    end
endmodule
`default_nettype wire
